// ===== sim/lct_line_timing_assertions.sv
`timescale 1ns/1ns
// ****
// Pin timing checks
// ****
module lct_line_timing_assertions (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic EXT_RANGE,
  input wire logic FIRST_TRANSFER_GATE,
  input wire logic SECOND_TRANSFER_GATE,
  input wire logic PHASE_ONE,
  input wire logic PHASE_TWO,
  input wire logic RESET_GATE_PIN,
  input wire logic [2:0] DRAIN_GATE,
  input wire logic EXTENDED_RANGE_MODE,
  input wire logic PIXEL_STROBE,
  input wire logic BUSY
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  a_idle_barrier: assert property (!BUSY |-> !FIRST_TRANSFER_GATE && !SECOND_TRANSFER_GATE)
    else $error("transfer gate on while idle");
  a_park_before: assert property (FIRST_TRANSFER_GATE || SECOND_TRANSFER_GATE |->
    PHASE_ONE && !PHASE_TWO) else $error("shift clocks not parked");
  a_both_on: assert property ($rose(FIRST_TRANSFER_GATE) |-> $rose(SECOND_TRANSFER_GATE))
    else $error("gates not raised together");
  a_second_late: assert property ($fell(FIRST_TRANSFER_GATE) |-> SECOND_TRANSFER_GATE ##24
    SECOND_TRANSFER_GATE ##1 !SECOND_TRANSFER_GATE) else $error("second gate timing wrong");
  a_phase_comp: assert property (PHASE_ONE != PHASE_TWO)
    else $error("phases not complementary");
  a_reset_once: assert property ($rose(PHASE_TWO) |-> RESET_GATE_PIN ##1 !RESET_GATE_PIN[*7])
    else $error("reset pulse wrong");
  a_strobe_edge: assert property (PIXEL_STROBE == $fell(PHASE_TWO))
    else $error("strobe not at phase two fall");
  a_drain_rise: assert property ((DRAIN_GATE & ~$past(DRAIN_GATE)) != 3'h0 |->
    $fell(FIRST_TRANSFER_GATE)) else $error("drain rose off the first gate fall");
  a_drain_fall: assert property ((~DRAIN_GATE & $past(DRAIN_GATE)) != 3'h0 |-> PIXEL_STROBE)
    else $error("drain fell off a shift edge");
  a_mode_copy: assert property (!$past(RST) |-> EXTENDED_RANGE_MODE == $past(EXT_RANGE))
    else $error("mode output lags");
  c_transfer: cover property ($fell(FIRST_TRANSFER_GATE));
  c_drain: cover property ($fell(DRAIN_GATE[1]));
  c_mode: cover property ($rose(EXTENDED_RANGE_MODE));
endmodule

bind lct_line_timing lct_line_timing_assertions u_chk (.*);

// ===== sim/lct_line_timing_tb.sv
`timescale 1ns/1ns
module lct_line_timing_tb
  import lct_pkg::*;
;
  logic clk_sys = 1'b0, rst = 1'b1, start = 1'b0, ext_range = 1'b0;
  logic tg1, tg2, ph1, ph2, rgp, strobe, done, busy, erm;
  logic [2:0] drain;
  logic [13:0] pix;
  logic [2:0][13:0] rem;
  int bad_count = 0, cmp_count = 0, cyc = 0;
  always #20 clk_sys = ~clk_sys;
  lct_line_timing dut (.CLK_SYS(clk_sys), .RST(rst), .CE(1'b1), .START(start), .RUN(1'b0),
    .EXT_RANGE(ext_range), .EXPOSURE_R(14'h0000), .EXPOSURE_G(14'h0064),
    .EXPOSURE_B(LCT_CELLS_M1), .FIRST_TRANSFER_GATE(tg1), .SECOND_TRANSFER_GATE(tg2),
    .PHASE_ONE(ph1), .PHASE_TWO(ph2), .RESET_GATE_PIN(rgp), .DRAIN_GATE(drain),
    .EXTENDED_RANGE_MODE(erm), .PIXEL_STROBE(strobe), .LINE_DONE(done), .BUSY(busy));
  lct_sensor_model model (.clk(clk_sys), .pins({tg1, tg2, ph1, ph2, rgp}), .drain(drain),
    .pix(pix), .rem(rem));
  task check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task t_mode;
    @(posedge clk_sys) ext_range <= 1'b1;
    step(2);
    check(16'(erm), 16'h0001);
    @(posedge clk_sys) ext_range <= 1'b0;
    step(2);
    check(16'(erm), 16'h0000);
    $display("mode test done");
  endtask
  task t_transfer;
    @(posedge clk_sys) start <= 1'b1;
    @(posedge clk_sys) start <= 1'b0;
    step(2);
    check(16'({busy, tg1, tg2, ph1, ph2}), 16'h0012);
    step(25);
    check(16'({tg1, tg2, ph1, ph2}), 16'h000E);
    step(25);
    check(16'({tg1, tg2, drain}), 16'h000B);
    step(25);
    check(16'({tg1, tg2}), 16'h0000);
    step(25);
    check(16'({ph1, ph2, rgp}), 16'h0003);
    $display("transfer test done");
  endtask
  task t_line;
    // A start during readout is held and opens the next line at line end
    @(posedge clk_sys) start <= 1'b1;
    @(posedge clk_sys) start <= 1'b0;
    while (done !== 1'b1) step(1);
    check(16'(strobe), 16'h0001);
    step(1);
    check(16'(pix), 16'h1F56);
    check(16'(rem[0]), 16'h0000);
    check(16'(rem[1]), 16'h0064);
    check(16'(rem[2]), 16'(LCT_CELLS_M1));
    step(30);
    check(16'({busy, tg1, tg2}), 16'h0007);
    check(16'(pix), 16'h0000);
    $display("line test done");
  endtask
  // Ceiling covers one line of 8022 periods plus margin
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_mode;
    t_transfer;
    t_line;
    tally_and_finish;
  end
endmodule

// ===== sim/lct_sensor_model.sv
`timescale 1ns/1ns
// ****
// Sensor: counts pixels, notes where each drain gate let go
// ****
module lct_sensor_model
  import lct_pkg::*;
(
  input wire logic clk,
  input wire lct_clocks_t pins,
  input wire logic [2:0] drain,
  output logic [13:0] pix,
  output logic [2:0][13:0] rem
);
  logic p2_q;
  logic [2:0] drn_q;
  always @(posedge clk) begin
    p2_q <= pins.phase_two;
    drn_q <= drain;
    if (pins.first_transfer_gate && pins.second_transfer_gate) begin
      pix <= LCT_ZERO14;
      rem <= {3{LCT_CELLS_M1}};
    end else if (p2_q && !pins.phase_two) begin
      pix <= pix + 14'h0001;
    end
    for (int c = 0; c < 3; c++) begin
      if (drn_q[c] && !drain[c]) begin
        rem[c] <= LCT_CELLS_M1 - pix;
      end
    end
  end
endmodule

// ===== verilog/lct_line_timing.sv
`timescale 1ns/1ns
// Functional notes
// R1 - Both transfer gates stay off while the photodiodes integrate.
// R2 - Line end stops shifting with phase one high, phase two low first.
// R3 - Parked registers then see both transfer gates turned on.
// R4 - First gate goes off while the second stays on.
// R5 - Second gate goes off after the first one.
// R6 - Complementary two-phase shifting resumes for readout during next integration.
// R7 - Sensor shifts all three channels together, one pixel per period.
// R8 - Sensor moves pixels to outputs on phase two falling edge.
// R9 - Reset gate pulses once before every pixel output.
// R10 - Drain gate high with first gate off discards light.
// R11 - Drain gate rises at first gate fall, falls inside line scan.
// R12 - Exposure runs from drain gate fall to next first gate fall.
// R13 - Each channel has its own independently timed drain gate.
// R14 - Drain gates rise together with the first gate falling edge.
// R15 - Drain gate falls aligned with a shift clock edge.
// R16 - Phases stay exact complements and stop only at period boundaries.
// R17 - A line takes 8022 shift periods.
// R18 - Mode output selects normal or extended reset gate swing.
// R19 - Drain gate falls when remaining periods equal the programmed count.
module lct_line_timing
  import lct_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  input wire logic START,
  input wire logic RUN,
  input wire logic EXT_RANGE,
  input wire logic [13:0] EXPOSURE_R,
  input wire logic [13:0] EXPOSURE_G,
  input wire logic [13:0] EXPOSURE_B,
  output logic FIRST_TRANSFER_GATE,
  output logic SECOND_TRANSFER_GATE,
  output logic PHASE_ONE,
  output logic PHASE_TWO,
  output logic RESET_GATE_PIN,
  output logic [2:0] DRAIN_GATE,
  output logic EXTENDED_RANGE_MODE,
  output logic PIXEL_STROBE,
  output logic LINE_DONE,
  output logic BUSY
);

  // ************************************************
  // Sequencer
  // ************************************************
  lct_state_t state;
  logic [7:0] tick;
  logic [13:0] period;
  logic half;
  logic pending;
  logic [13:0] expo [LCT_CHANNELS];
  lct_clocks_t clk_out;

  wire tick_end = (tick == LCT_ZERO8);
  // Opening cycle of the phase-one-high half: phase two falls on the pin one edge later
  wire pixel_edge = (state == LCT_READ) && half && (tick == (LCT_PHASE_CYC - 8'h01));
  // Opening cycle of the second-gate-only step, which makes the first gate fall on the pin
  wire drain_arm = (state == LCT_TG2_ONLY) && (tick == (LCT_TG_CYC - 8'h01));
  wire [13:0] remaining = LCT_CELLS_M1 - period;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pending <= 1'b0;
    end else if (CE) begin
      if (START) begin
        pending <= 1'b1;
      end else if (state == LCT_PARK) begin
        pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state <= LCT_IDLE;
      tick <= LCT_ZERO8;
      half <= 1'b0;
      period <= LCT_ZERO14;
    end else if (CE) begin
      case (state)
        LCT_IDLE: begin
          if (pending) begin
            state <= LCT_PARK;  // [R2]
            tick <= LCT_TG_CYC - 8'h01;
          end
        end
        LCT_PARK: begin
          if (tick_end) begin
            state <= LCT_TG_BOTH;  // [R3]
            tick <= LCT_TG_CYC - 8'h01;
          end else begin
            tick <= tick - 8'h01;
          end
        end
        LCT_TG_BOTH: begin
          if (tick_end) begin
            state <= LCT_TG2_ONLY;  // [R4]
            tick <= LCT_TG_CYC - 8'h01;
          end else begin
            tick <= tick - 8'h01;
          end
        end
        LCT_TG2_ONLY: begin
          if (tick_end) begin
            state <= LCT_TG_OFF;  // [R5]
            tick <= LCT_TG_CYC - 8'h01;
          end else begin
            tick <= tick - 8'h01;
          end
        end
        LCT_TG_OFF: begin
          if (tick_end) begin
            state <= LCT_READ;  // [R6]
            tick <= LCT_PHASE_CYC - 8'h01;
            half <= 1'b0;
            period <= LCT_ZERO14;
          end else begin
            tick <= tick - 8'h01;
          end
        end
        LCT_READ: begin
          if (!tick_end) begin
            tick <= tick - 8'h01;
          end else begin
            tick <= LCT_PHASE_CYC - 8'h01;
            half <= ~half;
            if (half) begin
              if (period == LCT_CELLS_M1) begin  // [R17]
                // Stop only on a full period so phases never stop mid-cycle
                state <= (pending || RUN) ? LCT_PARK : LCT_IDLE;  // [R16]
                tick <= LCT_TG_CYC - 8'h01;
                period <= LCT_ZERO14;
              end else begin
                period <= period + 14'h0001;
              end
            end
          end
        end
        default: begin
          state <= LCT_IDLE;
        end
      endcase
    end
  end

  // ************************************************
  // Pin drive
  // ************************************************
  // Levels decoded per state; the pin registers below add one cycle to every pin
  always_comb begin
    clk_out.first_transfer_gate = 1'b0;
    clk_out.second_transfer_gate = 1'b0;
    clk_out.phase_one = 1'b1;
    clk_out.phase_two = 1'b0;
    clk_out.reset_gate_pin = 1'b0;
    case (state)
      LCT_IDLE: begin
        // Integration: both gates at barrier, registers parked
        clk_out.first_transfer_gate = 1'b0;  // [R1]
        clk_out.second_transfer_gate = 1'b0;  // [R1]
        clk_out.phase_one = 1'b1;
        clk_out.phase_two = 1'b0;
      end
      LCT_PARK: begin
        // Shifting stopped before any gate moves
        clk_out.first_transfer_gate = 1'b0;
        clk_out.second_transfer_gate = 1'b0;
        clk_out.phase_one = 1'b1;  // [R2]
        clk_out.phase_two = 1'b0;  // [R2]
      end
      LCT_TG_BOTH: begin
        clk_out.first_transfer_gate = 1'b1;  // [R3]
        clk_out.second_transfer_gate = 1'b1;  // [R3]
        clk_out.phase_one = 1'b1;
        clk_out.phase_two = 1'b0;
      end
      LCT_TG2_ONLY: begin
        clk_out.first_transfer_gate = 1'b0;  // [R4]
        clk_out.second_transfer_gate = 1'b1;  // [R4]
        clk_out.phase_one = 1'b1;
        clk_out.phase_two = 1'b0;
      end
      LCT_TG_OFF: begin
        // Registers isolated again; one more step settles before shifting
        clk_out.first_transfer_gate = 1'b0;
        clk_out.second_transfer_gate = 1'b0;  // [R5]
        clk_out.phase_one = 1'b1;
        clk_out.phase_two = 1'b0;
      end
      LCT_READ: begin
        // Both phases come from one bit, so they can never overlap
        clk_out.phase_one = half;  // [R6] [R16]
        clk_out.phase_two = ~half;  // [R6] [R16]
        // Reset pulse opens the phase-two-high half, ahead of its falling edge
        clk_out.reset_gate_pin = !half &&
                                 (tick > (LCT_PHASE_CYC - 8'h01 - LCT_RST_CYC));  // [R9]
      end
      default: begin
        clk_out.first_transfer_gate = 1'b0;
        clk_out.second_transfer_gate = 1'b0;
      end
    endcase
  end

  // ************************************************
  // Pin registers
  // ************************************************
  // Transfer gates
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      FIRST_TRANSFER_GATE <= 1'b0;
      SECOND_TRANSFER_GATE <= 1'b0;
    end else if (CE) begin
      FIRST_TRANSFER_GATE <= clk_out.first_transfer_gate;
      SECOND_TRANSFER_GATE <= clk_out.second_transfer_gate;
    end
  end

  // Shift clocks leave reset parked, so the first line starts from a clean phase
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      PHASE_ONE <= 1'b1;
      PHASE_TWO <= 1'b0;
    end else if (CE) begin
      PHASE_ONE <= clk_out.phase_one;
      PHASE_TWO <= clk_out.phase_two;
    end
  end

  // Pulse width is one system clock cycle
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      RESET_GATE_PIN <= 1'b0;
    end else if (CE) begin
      RESET_GATE_PIN <= clk_out.reset_gate_pin;
    end
  end

  // Mode only follows the request; the swing itself is set by the analog driver
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      EXTENDED_RANGE_MODE <= 1'b0;
    end else if (CE) begin
      EXTENDED_RANGE_MODE <= EXT_RANGE;  // [R18]
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      PIXEL_STROBE <= 1'b0;
      LINE_DONE <= 1'b0;
      BUSY <= 1'b0;
    end else if (CE) begin
      // Registered together with phase two, so the strobe lands on its falling edge
      PIXEL_STROBE <= pixel_edge;  // [R7] [R8]
      LINE_DONE <= pixel_edge && (period == LCT_CELLS_M1);  // [R17]
      BUSY <= (state != LCT_IDLE);
    end
  end

  // ************************************************
  // Exposure drain gates
  // ************************************************
  assign expo[0] = EXPOSURE_R;
  assign expo[1] = EXPOSURE_G;
  assign expo[2] = EXPOSURE_B;

  // Each channel keeps its own count against the shared period counter, so colour balance needs no per-channel timer
  generate
    for (genvar ch = 0; ch < LCT_CHANNELS; ch++) begin : g_drain
      logic [13:0] count;
      logic gate;
      logic keep_full;
      logic drop;
      // A count of LCT_CELLS_M1 (8021) periods or more leaves the gate low: full exposure
      assign keep_full = (expo[ch] >= LCT_CELLS_M1);
      // Fall on the phase two edge that leaves exactly count periods of the line
      assign drop = pixel_edge && (remaining == count);

      always_ff @(posedge CLK_SYS) begin
        if (RST) begin
          count <= LCT_ZERO14;
        end else if (CE) begin
          if (drain_arm) begin
            // Sampled once per line, so a change mid-line waits for the next transfer
            count <= expo[ch];  // [R13] [R19]
          end
        end
      end

      always_ff @(posedge CLK_SYS) begin
        if (RST) begin
          gate <= 1'b0;
        end else if (CE) begin
          if (drain_arm) begin
            // Rises with the first gate falling edge to dump light from here on
            gate <= !keep_full;  // [R10] [R11] [R14]
          end else if (drop) begin
            gate <= 1'b0;  // [R12] [R15] [R19]
          end
        end
      end

      assign DRAIN_GATE[ch] = gate;
    end
  endgenerate

endmodule

// ===== verilog/lct_pkg.sv
package lct_pkg;
  // Cells per register; one shift period moves one pixel out of each channel
  localparam int LCT_CELLS = 8022;
  localparam logic [13:0] LCT_CELLS_M1 = 14'h1F55;
  localparam int LCT_CHANNELS = 3;
  // System clock period and phase time of the shift clocks
  localparam int LCT_CLK_NS = 40;
  localparam int LCT_PHASE_NS = 160;
  localparam int LCT_PHASE_CYC_I = (LCT_PHASE_NS + LCT_CLK_NS - 1) / LCT_CLK_NS;
  localparam logic [7:0] LCT_PHASE_CYC = LCT_PHASE_CYC_I[7:0];
  // Transfer gate step time
  localparam int LCT_TG_NS = 1000;
  localparam int LCT_TG_CYC_I = (LCT_TG_NS + LCT_CLK_NS - 1) / LCT_CLK_NS;
  localparam logic [7:0] LCT_TG_CYC = LCT_TG_CYC_I[7:0];
  // Reset gate pulse width
  localparam int LCT_RST_NS = 40;
  localparam int LCT_RST_CYC_I = (LCT_RST_NS + LCT_CLK_NS - 1) / LCT_CLK_NS;
  localparam logic [7:0] LCT_RST_CYC = LCT_RST_CYC_I[7:0];
  localparam logic [7:0] LCT_ZERO8 = 8'h00;
  localparam logic [13:0] LCT_ZERO14 = 14'h0000;

  typedef enum logic [2:0] {
    LCT_IDLE = 3'b000,
    LCT_PARK = 3'b001,
    LCT_TG_BOTH = 3'b010,
    LCT_TG2_ONLY = 3'b011,
    LCT_TG_OFF = 3'b100,
    LCT_READ = 3'b101
  } lct_state_t;

  typedef struct packed {
    logic first_transfer_gate;
    logic second_transfer_gate;
    logic phase_one;
    logic phase_two;
    logic reset_gate_pin;
  } lct_clocks_t;
endpackage
